// *** logic/tw8_waveform_unit.sv ***
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
// Function
// - Reset forces compare output state to zero
// - Nonzero output mode replaces port value
// - Pin driven only when direction is output
// - Output mode zero leaves state untouched
// - Mode change acts at next match; force
// - Counting depends on waveform mode only
// - Mode 0 counts up, wraps ff to 00
// - Normal mode overflow set as count hits zero
// - Count writes accepted any time
// - Mode 2 clears counter at compare A
// - Unbuffered compare A, missed match wraps
// - Mode 1 toggles output A on match
// - Clear-on-compare overflow at max to zero
// - Modes 3 and 7 are fast PWM
// - Fast PWM clears after reaching top
// - Mode 2 clear/set, mode 3 opposite
// - Fast PWM overflow at top
// - Toggle A only with mode bit 2
// - Extreme compare values give spike or level
// - Fast PWM compares buffered, toggle half rate
// - Buffered compares load at top/bottom
// - Match sets flag on the next clock, W1C
// - Force updates output only
// - Count write blocks next tick matches
module tw8_waveform_unit
    import tw8_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       timerTick,
    input  wire tw8_bus_s   bus,
    output tw8_pin_s        pinA,
    output tw8_pin_s        pinB,
    output logic [7:0]      rdata
);
    // ------------------------------------------------------------
    // Software state
    // ------------------------------------------------------------
    logic [7:0] ctrl_reg;
    logic [7:0] port_reg;
    logic [7:0] count_reg;
    logic [2:0] flags_reg;
    logic [1:0] force_reg;
    logic       block_reg;
    logic [7:0] cmpBuf_reg [2];
    logic [7:0] cmpAct_reg [2];
    logic [1:0] oc_reg;
    logic [1:0] com [2];
    tw8_wgm_e   wgm;
    logic       isPwm;
    logic [7:0] top;
    logic       cntWr;
    logic       wrapPwm;
    logic       clearNow;
    logic       ovfSet;
    logic [1:0] match;
    logic [1:0] cmpWr;

    assign wgm    = tw8_wgm_e'(ctrl_reg[2:0]);
    assign com[0] = ctrl_reg[CTRL_MODEA_LSB +: 2];
    assign com[1] = ctrl_reg[CTRL_MODEB_LSB +: 2];
    assign cntWr  = bus.wr && bus.addr == IDX_COUNT;
    assign cmpWr[0] = bus.wr && bus.addr == IDX_CMPA;
    assign cmpWr[1] = bus.wr && bus.addr == IDX_CMPB;

    // ------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------
    always_comb begin
        isPwm = 1'b0;
        top   = COUNT_MAX;
        case (wgm)
            TW8_FAST8: begin
                isPwm = 1'b1;
            end
            TW8_FASTA: begin
                isPwm = 1'b1;
                top   = cmpAct_reg[0];
            end
            default: begin
                isPwm = 1'b0;
            end
        endcase
    end

    // Software write wins over the tick in the same cycle
    assign wrapPwm  = isPwm && timerTick && count_reg == top && !cntWr;
    assign clearNow = wrapPwm || (wgm == TW8_CTC && timerTick && !cntWr
                      && count_reg == cmpAct_reg[0]);
    assign ovfSet   = timerTick && !cntWr
                      && (isPwm ? count_reg == top : count_reg == COUNT_MAX);

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            count_reg <= COUNT_BOT;
        end else if (cntWr) begin
            count_reg <= bus.wdata;
        end else if (clearNow) begin
            count_reg <= COUNT_BOT;
        end else if (timerTick) begin
            // Missed compare simply runs on and wraps
            count_reg <= count_reg + 8'h01;
        end
    end

    // Blocks matches for the whole next timer period, even stopped
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            block_reg <= 1'b0;
        end else if (cntWr) begin
            block_reg <= 1'b1;
        end else if (timerTick) begin
            block_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            port_reg <= PORT_RST;
        end else if (bus.wr && bus.addr == IDX_CTRL) begin
            ctrl_reg <= bus.wdata;
        end else if (bus.wr && bus.addr == IDX_PORT) begin
            port_reg <= bus.wdata;
        end
    end

    // Force strobes are one cycle; ignored in PWM modes
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            force_reg <= 2'b00;
        end else if (bus.wr && bus.addr == IDX_FORCE && !isPwm) begin
            force_reg <= bus.wdata[1:0];
        end else begin
            force_reg <= 2'b00;
        end
    end

    // ------------------------------------------------------------
    // Per channel compare and output
    // ------------------------------------------------------------
    for (genvar i = 0; i < 2; i++) begin : g_ch
        assign match[i] = timerTick && !block_reg && !cntWr
                          && count_reg == cmpAct_reg[i];

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                cmpBuf_reg[i] <= COUNT_BOT;
                cmpAct_reg[i] <= COUNT_BOT;
            end else begin
                if (cmpWr[i]) begin
                    cmpBuf_reg[i] <= bus.wdata;
                end
                if (!isPwm) begin
                    // Unbuffered outside PWM
                    cmpAct_reg[i] <= cmpWr[i] ? bus.wdata : cmpBuf_reg[i];
                end else if (wrapPwm) begin
                    cmpAct_reg[i] <= cmpBuf_reg[i];
                end
            end
        end

        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                oc_reg[i] <= 1'b0;
            end else if (com[i] == 2'b00) begin
                oc_reg[i] <= oc_reg[i];
            end else if (!isPwm) begin
                if (match[i] || force_reg[i]) begin
                    case (com[i])
                        2'b01:   oc_reg[i] <= !oc_reg[i];
                        2'b10:   oc_reg[i] <= 1'b0;
                        default: oc_reg[i] <= 1'b1;
                    endcase
                end
            end else if (com[i] == 2'b01) begin
                if (match[i] && i == 0 && wgm[2]) begin
                    oc_reg[i] <= !oc_reg[i];
                end
            end else if (wrapPwm) begin
                // Bottom wins over a match at top: steady level
                oc_reg[i] <= (com[i] == 2'b10);
            end else if (match[i]) begin
                oc_reg[i] <= (com[i] == 2'b11);
            end
        end
    end

    // ------------------------------------------------------------
    // Flags, set beats clear
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            flags_reg <= 3'h0;
        end else begin
            flags_reg <= (flags_reg & ~((bus.wr && bus.addr == IDX_FLAGS)
                         ? bus.wdata[2:0] : 3'h0))
                         | {match[1], match[0], ovfSet};
        end
    end

    // ------------------------------------------------------------
    // Pins, registered
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pinA <= '0;
            pinB <= '0;
        end else begin
            pinA.out <= (com[0] != 2'b00) ? oc_reg[0] : port_reg[PORT_VAL_LSB];
            pinB.out <= (com[1] != 2'b00) ? oc_reg[1] : port_reg[PORT_VAL_LSB + 1];
            pinA.oe  <= port_reg[PORT_DIR_LSB];
            pinB.oe  <= port_reg[PORT_DIR_LSB + 1];
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (!bus.rd) begin
            rdata <= 8'h00;
        end else begin
            case (bus.addr)
                IDX_CTRL:   rdata <= ctrl_reg;
                IDX_COUNT:  rdata <= count_reg;
                IDX_CMPA:   rdata <= cmpBuf_reg[0];
                IDX_CMPB:   rdata <= cmpBuf_reg[1];
                IDX_FLAGS:  rdata <= {5'h00, flags_reg};
                IDX_PORT:   rdata <= port_reg;
                IDX_STATUS: rdata <= {6'h00, oc_reg};
                default:    rdata <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence sNormWrap;
        timerTick && !cntWr && wgm == TW8_NORMAL && count_reg == COUNT_MAX;
    endsequence
    sequence sPwmBottom;
        wrapPwm && com[0] == 2'b10;
    endsequence

    AST_OC_RESET: assert property (@(posedge mclk) $fell(rst) |-> oc_reg == 2'b00)
        else $error("compare state not zero after reset");
    AST_OVERRIDE: assert property (@(posedge mclk) disable iff (rst)
        com[0] != 2'b00 |=> pinA.out == $past(oc_reg[0]))
        else $error("pin A not driven by compare state");
    AST_DIR: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> pinB.oe == $past(port_reg[PORT_DIR_LSB + 1]))
        else $error("pin B enable wrong");
    AST_HOLD: assert property (@(posedge mclk) disable iff (rst)
        match[0] && com[0] == 2'b00 |=> $stable(oc_reg[0]))
        else $error("output changed with mode zero");
    AST_WRAP: assert property (@(posedge mclk) disable iff (rst)
        sNormWrap |=> count_reg == COUNT_BOT && flags_reg[FLAG_OVF])
        else $error("normal wrap or overflow wrong");
    AST_CTC: assert property (@(posedge mclk) disable iff (rst)
        wgm == TW8_CTC && timerTick && !cntWr && count_reg == cmpAct_reg[0]
        |=> count_reg == COUNT_BOT)
        else $error("counter not cleared at compare");
    AST_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
        match[0] && !isPwm && com[0] == 2'b01 |=> oc_reg[0] != $past(oc_reg[0]))
        else $error("no toggle on match");
    AST_PWM_SET: assert property (@(posedge mclk) disable iff (rst)
        sPwmBottom |=> oc_reg[0] ##1 (oc_reg[0] || $past(match[0])))
        else $error("output not set at bottom");
    AST_FLAG: assert property (@(posedge mclk) disable iff (rst)
        match[1] |=> flags_reg[FLAG_CMPB])
        else $error("compare flag not set");
    AST_BLOCK: assert property (@(posedge mclk) disable iff (rst)
        cntWr ##1 (!cntWr && timerTick) |-> match == 2'b00)
        else $error("match not blocked after count write");

    // ------------------------------------------------------------
    // Counter, flag and compare buffer checks
    // ------------------------------------------------------------
    sequence sFlagClrA;
        bus.wr && bus.addr == IDX_FLAGS && bus.wdata[FLAG_CMPA];
    endsequence

    AST_CNT_WRITE: assert property (@(posedge mclk) disable iff (rst)
        cntWr |=> count_reg == $past(bus.wdata))
        else $error("count write not taken");
    AST_NORM_NOCLR: assert property (@(posedge mclk) disable iff (rst)
        wgm == TW8_NORMAL && timerTick && !cntWr |=> count_reg == $past(count_reg) + 8'h01)
        else $error("normal mode did not increment");
    AST_TICK_ONLY: assert property (@(posedge mclk) disable iff (rst)
        !timerTick && !cntWr |=> $stable(count_reg))
        else $error("count moved without tick");
    AST_WGM_ONLY: assert property (@(posedge mclk) disable iff (rst)
        clearNow |-> wgm == TW8_CTC || isPwm)
        else $error("clear in a mode without clear");
    AST_OVF_CTC: assert property (@(posedge mclk) disable iff (rst)
        timerTick && !cntWr && wgm == TW8_CTC && count_reg == COUNT_MAX
        |=> flags_reg[FLAG_OVF])
        else $error("overflow not set in clear mode");
    AST_OVF_PWM: assert property (@(posedge mclk) disable iff (rst)
        wrapPwm |=> flags_reg[FLAG_OVF])
        else $error("overflow not set at top");
    AST_OVF_ONLY_SET: assert property (@(posedge mclk) disable iff (rst)
        flags_reg[FLAG_OVF] && !(bus.wr && bus.addr == IDX_FLAGS) |=> flags_reg[FLAG_OVF])
        else $error("overflow cleared by hardware");
    AST_PWM_CLEAR: assert property (@(posedge mclk) disable iff (rst)
        wrapPwm |=> count_reg == COUNT_BOT)
        else $error("counter not cleared after top");
    AST_FAST8_TOP: assert property (@(posedge mclk) disable iff (rst)
        wgm == TW8_FAST8 |-> top == COUNT_MAX)
        else $error("fixed top wrong");
    AST_FASTA_TOP: assert property (@(posedge mclk) disable iff (rst)
        wgm == TW8_FASTA |-> top == cmpAct_reg[0])
        else $error("compare top wrong");
    AST_FLAG_A: assert property (@(posedge mclk) disable iff (rst)
        match[0] |=> flags_reg[FLAG_CMPA])
        else $error("compare A flag not set");
    AST_FLAG_CLR: assert property (@(posedge mclk) disable iff (rst)
        sFlagClrA ##0 !match[0] |=> !flags_reg[FLAG_CMPA])
        else $error("compare A flag not cleared");
    AST_BLOCK_HOLD: assert property (@(posedge mclk) disable iff (rst)
        block_reg |-> match == 2'b00)
        else $error("match while blocked");
    AST_BUF_HOLD: assert property (@(posedge mclk) disable iff (rst)
        isPwm && !wrapPwm |=> $stable(cmpAct_reg[0]))
        else $error("active compare changed off top");
    AST_BUF_LOAD: assert property (@(posedge mclk) disable iff (rst)
        wrapPwm |=> cmpAct_reg[1] == $past(cmpBuf_reg[1]))
        else $error("active compare not loaded at top");
    AST_CTC_UNBUF: assert property (@(posedge mclk) disable iff (rst)
        !isPwm && cmpWr[0] |=> cmpAct_reg[0] == $past(bus.wdata))
        else $error("compare not written directly");

    // ------------------------------------------------------------
    // Output checks
    // ------------------------------------------------------------
    sequence sPwmMatchInv;
        isPwm && match[0] && !wrapPwm && com[0] == 2'b11;
    endsequence

    AST_PIN_RESET: assert property (@(posedge mclk) $fell(rst) |-> !pinA.out && !pinB.out)
        else $error("pins not low after reset");
    AST_PIN_PORT: assert property (@(posedge mclk) disable iff (rst)
        com[1] == 2'b00 |=> pinB.out == $past(port_reg[PORT_VAL_LSB + 1]))
        else $error("pin B not showing port value");
    AST_DIR_A: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> pinA.oe == $past(port_reg[PORT_DIR_LSB]))
        else $error("pin A enable wrong");
    AST_HOLD_B: assert property (@(posedge mclk) disable iff (rst)
        match[1] && com[1] == 2'b00 |=> $stable(oc_reg[1]))
        else $error("output B changed with mode zero");
    AST_FORCE_ACT: assert property (@(posedge mclk) disable iff (rst)
        force_reg[0] && !isPwm && com[0] == 2'b11 |=> oc_reg[0])
        else $error("force did not set output");
    AST_PWM_NOFORCE: assert property (@(posedge mclk) disable iff (rst)
        isPwm |=> force_reg == 2'b00)
        else $error("force taken in PWM");
    AST_FORCE_NOFLAG: assert property (@(posedge mclk) disable iff (rst)
        force_reg[0] && !match[0] && !flags_reg[FLAG_CMPA] |=> !flags_reg[FLAG_CMPA])
        else $error("force set the flag");
    AST_PWM_MATCH: assert property (@(posedge mclk) disable iff (rst)
        sPwmMatchInv |=> oc_reg[0])
        else $error("inverting match did not set");
    AST_NO_B_TOGGLE: assert property (@(posedge mclk) disable iff (rst)
        isPwm && com[1] == 2'b01 |=> $stable(oc_reg[1]))
        else $error("output B toggled in PWM");
    AST_A_TOGGLE_PWM: assert property (@(posedge mclk) disable iff (rst)
        match[0] && isPwm && com[0] == 2'b01 && !wgm[2] |=> $stable(oc_reg[0]))
        else $error("output A toggled without mode bit");
endmodule

// *** logic/tw8_pkg.sv ***
package tw8_pkg;
    // ------------------------------------------------------------
    // Register indices on the plain register port
    // ------------------------------------------------------------
    localparam int         ADDR_W     = 3;
    localparam logic [2:0] IDX_CTRL   = 3'h0;
    localparam logic [2:0] IDX_COUNT  = 3'h1;
    localparam logic [2:0] IDX_CMPA   = 3'h2;
    localparam logic [2:0] IDX_CMPB   = 3'h3;
    localparam logic [2:0] IDX_FLAGS  = 3'h4;
    localparam logic [2:0] IDX_FORCE  = 3'h5;
    localparam logic [2:0] IDX_PORT   = 3'h6;
    localparam logic [2:0] IDX_STATUS = 3'h7;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_MODEA_LSB = 6;
    localparam int CTRL_MODEB_LSB = 4;
    localparam int FLAG_OVF       = 0;
    localparam int FLAG_CMPA      = 1;
    localparam int FLAG_CMPB      = 2;
    localparam int PORT_DIR_LSB   = 0;
    localparam int PORT_VAL_LSB   = 4;

    // ------------------------------------------------------------
    // Reset values and fixed counts
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] PORT_RST   = 8'h00;
    localparam logic [7:0] COUNT_MAX  = 8'hff;
    localparam logic [7:0] COUNT_BOT  = 8'h00;

    typedef enum logic [2:0] {
        TW8_NORMAL = 3'b000,
        TW8_PCOR8  = 3'b001,
        TW8_CTC    = 3'b010,
        TW8_FAST8  = 3'b011,
        TW8_RSV4   = 3'b100,
        TW8_PCORA  = 3'b101,
        TW8_RSV6   = 3'b110,
        TW8_FASTA  = 3'b111
    } tw8_wgm_e;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } tw8_bus_s;

    typedef struct packed {
        logic out;
        logic oe;
    } tw8_pin_s;
endpackage

// *** verification/test_tw8_waveform_unit.sv ***
`timescale 1ns/1ns
module test_tw8_waveform_unit
    import tw8_pkg::*;
;
    // ------------------------------------------------------------
    // Stimulus and observation
    // ------------------------------------------------------------
    logic       mclk;
    logic       rst;
    logic       timerTick;
    tw8_bus_s   bus;
    tw8_pin_s   pinA;
    tw8_pin_s   pinB;
    logic [7:0] rdata;
    int         failures;
    int         testsRun;
    int         cycles;

    tw8_waveform_unit u_dut (
        .mclk      (mclk),
        .rst       (rst),
        .timerTick (timerTick),
        .bus       (bus),
        .pinA      (pinA),
        .pinB      (pinB),
        .rdata     (rdata)
    );

    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // ------------------------------------------------------------
    // Bus, tick and compare tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkPin(input tw8_pin_s got, input tw8_pin_s exp);
        testsRun++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Read data only valid in the cycle after the strobe
    task automatic rdChk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1;
        chk8(rdata, exp);
    endtask

    task automatic tick(input int n);
        repeat (n) begin
            @(posedge mclk);
            timerTick <= 1'b1;
            @(posedge mclk);
            timerTick <= 1'b0;
        end
    endtask

    // Pins are registered behind the state, so let two edges pass
    task automatic settle();
        repeat (2) @(posedge mclk);
        #1;
    endtask

    task automatic completeRun();
        $display("Comparisons %0d, mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Hang guard well above the few hundred cycles the sequence needs
    initial begin
        cycles = 0;
        forever begin
            @(posedge mclk);
            cycles++;
            if (cycles >= 3000) begin
                failures++;
                completeRun();
            end
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures = 0;
        testsRun = 0;
        rst = 1'b1;
        timerTick = 1'b0;
        bus = '0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rdChk(IDX_CTRL, CTRL_RST);
        rdChk(IDX_STATUS, 8'h00);
        rdChk(IDX_FLAGS, 8'h00);
        chkPin(pinA, '{out: 1'b0, oe: 1'b0});
        // Port value shown until the channel mode is nonzero
        wr(IDX_PORT, 8'h11);
        settle();
        chkPin(pinA, '{out: 1'b1, oe: 1'b1});
        wr(IDX_CTRL, 8'hc0);
        settle();
        chkPin(pinA, '{out: 1'b0, oe: 1'b1});
        // Force with set, clear, toggle in normal mode
        wr(IDX_FORCE, 8'h01);
        rdChk(IDX_STATUS, 8'h01);
        settle();
        chkPin(pinA, '{out: 1'b1, oe: 1'b1});
        wr(IDX_CTRL, 8'h80);
        wr(IDX_FORCE, 8'h01);
        rdChk(IDX_STATUS, 8'h00);
        wr(IDX_CTRL, 8'h40);
        wr(IDX_FORCE, 8'h01);
        rdChk(IDX_STATUS, 8'h01);
        rdChk(IDX_FLAGS, 8'h00);
        rdChk(IDX_COUNT, 8'h00);
        wr(IDX_CTRL, 8'h00);
        wr(IDX_FORCE, 8'h01);
        rdChk(IDX_STATUS, 8'h01);
        wr(IDX_PORT, 8'h00);
        settle();
        chkPin(pinA, '{out: 1'b0, oe: 1'b0});
        // Normal mode wrap and overflow
        wr(IDX_COUNT, 8'hfe);
        rdChk(IDX_COUNT, 8'hfe);
        tick(2);
        rdChk(IDX_COUNT, 8'h00);
        rdChk(IDX_FLAGS, 8'h01);
        wr(IDX_FLAGS, 8'h01);
        rdChk(IDX_FLAGS, 8'h00);
        // Count write hides a match on the next tick only
        wr(IDX_CMPA, 8'h05);
        wr(IDX_COUNT, 8'h05);
        tick(1);
        rdChk(IDX_FLAGS, 8'h00);
        wr(IDX_COUNT, 8'h04);
        tick(2);
        rdChk(IDX_FLAGS, 8'h02);
        wr(IDX_FLAGS, 8'h02);
        // Clear on compare A with toggle
        wr(IDX_CTRL, 8'h42);
        wr(IDX_CMPA, 8'h03);
        wr(IDX_COUNT, 8'h00);
        tick(4);
        rdChk(IDX_COUNT, 8'h00);
        rdChk(IDX_STATUS, 8'h00);
        rdChk(IDX_FLAGS, 8'h02);
        wr(IDX_FLAGS, 8'h02);
        wr(IDX_COUNT, 8'hfd);
        tick(3);
        rdChk(IDX_COUNT, 8'h00);
        rdChk(IDX_FLAGS, 8'h01);
        wr(IDX_FLAGS, 8'h01);
        // Fast PWM, non-inverting, buffered compares
        wr(IDX_CTRL, 8'h83);
        wr(IDX_CMPB, 8'h80);
        wr(IDX_CMPA, 8'h01);
        wr(IDX_COUNT, 8'hfe);
        tick(2);
        rdChk(IDX_COUNT, 8'h00);
        rdChk(IDX_STATUS, 8'h01);
        rdChk(IDX_FLAGS, 8'h01);
        wr(IDX_FLAGS, 8'h01);
        tick(2);
        rdChk(IDX_STATUS, 8'h00);
        rdChk(IDX_FLAGS, 8'h02);
        wr(IDX_FLAGS, 8'h02);
        // New compare waits for top, so no match at count two
        wr(IDX_CMPA, 8'h02);
        rdChk(IDX_CMPA, 8'h02);
        tick(1);
        rdChk(IDX_FLAGS, 8'h00);
        wr(IDX_FORCE, 8'h01);
        rdChk(IDX_STATUS, 8'h00);
        // Channel B pin follows port while its mode is zero
        wr(IDX_PORT, 8'h22);
        settle();
        chkPin(pinB, '{out: 1'b1, oe: 1'b1});
        chkPin(pinA, '{out: 1'b0, oe: 1'b0});
        // Top from compare A, toggle at zero gives half rate
        wr(IDX_CTRL, 8'h47);
        wr(IDX_CMPA, 8'h00);
        wr(IDX_COUNT, 8'h01);
        tick(1);
        tick(3);
        rdChk(IDX_COUNT, 8'h00);
        rdChk(IDX_STATUS, 8'h01);
        rdChk(IDX_FLAGS, 8'h03);
        wr(IDX_FLAGS, 8'h03);
        // No toggle without the third mode bit
        wr(IDX_CTRL, 8'h43);
        tick(1);
        rdChk(IDX_STATUS, 8'h01);
        // Inverting: clear at bottom, set on match
        wr(IDX_CTRL, 8'hc3);
        wr(IDX_CMPA, 8'h01);
        wr(IDX_COUNT, 8'hff);
        tick(1);
        rdChk(IDX_STATUS, 8'h00);
        tick(2);
        rdChk(IDX_STATUS, 8'h01);
        // Compare at max: bottom wins, steady low
        wr(IDX_CMPA, 8'hff);
        wr(IDX_COUNT, 8'hfe);
        tick(2);
        wr(IDX_COUNT, 8'hfe);
        tick(2);
        rdChk(IDX_STATUS, 8'h00);
        // Force on channel B in normal mode
        wr(IDX_CTRL, 8'h10);
        wr(IDX_FORCE, 8'h02);
        rdChk(IDX_STATUS, 8'h02);
        settle();
        chkPin(pinB, '{out: 1'b1, oe: 1'b1});
        completeRun();
    end
endmodule
